// ### design/fllcs_pkg.sv
package fllcs_pkg;

    // ************************************************************
    // Register indices on the two-bit register port.
    // ************************************************************
    localparam logic [1:0] ADDR_CTRL_ONE = 2'h0;
    localparam logic [1:0] ADDR_CTRL_TWO = 2'h1;
    localparam logic [1:0] ADDR_TRIM     = 2'h2;
    localparam logic [1:0] ADDR_STATUS   = 2'h3;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h40;
    // Trim reset value is arbitrary mid-scale.
    localparam logic [7:0] TRIM_RESET     = 8'h80;

    // ************************************************************
    // Field positions of the first control register.
    // ************************************************************
    localparam int CLOCK_SOURCE_SELECT_HI   = 7;
    localparam int CLOCK_SOURCE_SELECT_LO   = 6;
    localparam int REFERENCE_DIVIDER_SELECT_HI   = 5;
    localparam int REFERENCE_DIVIDER_SELECT_LO   = 3;
    localparam int INTERNAL_REFERENCE_SELECT_BIT = 2;
    localparam int IRCLK_BIT = 1;
    localparam int IRSTP_BIT = 0;

    // ************************************************************
    // Field positions of the second control register.
    // ************************************************************
    localparam int BUS_DIVIDER_SELECT_HI   = 7;
    localparam int BUS_DIVIDER_SELECT_LO   = 6;
    localparam int RANGE_BIT = 5;
    localparam int HGO_BIT   = 4;
    localparam int LP_BIT    = 3;
    localparam int OSCILLATOR_REQUEST_BIT = 2;
    localparam int ERCLK_BIT = 1;
    localparam int ERSTP_BIT = 0;

    // ************************************************************
    // Clock source select codes.
    // ************************************************************
    localparam logic [1:0] SRC_LOOP     = 2'h0;
    localparam logic [1:0] SRC_INTERNAL = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;

    typedef enum logic [6:0] {
        FLLCS_LOOP_ENGAGED_INTERNAL       = 7'h01,
        FLLCS_LOOP_ENGAGED_EXTERNAL       = 7'h02,
        FLLCS_BYPASSED_INTERNAL           = 7'h04,
        FLLCS_BYPASSED_INTERNAL_LOW_POWER = 7'h08,
        FLLCS_BYPASSED_EXTERNAL           = 7'h10,
        FLLCS_BYPASSED_EXTERNAL_LOW_POWER = 7'h20,
        FLLCS_STOP                        = 7'h40
    } fllcs_mode_t;

endpackage : fllcs_pkg

// ### design/fllcs_clock_source_unit.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Out of reset the unit runs loop-engaged-internal.
// - Selected source passes a bus divider of 1, 2, 4 or 8.
// - Bus clock runs at half the divided unit output.
// - Debug clock is loop oscillator divided by two, ignoring the bus divider.
// - Loop reference is divided by a ratio from a three-bit field.
// - Internal reference takes a nine-bit software trim value.
// - Internal or external reference up to 5 MHz controls the loop.
// - Engaged-internal: output from loop on internal reference, debug from loop.
// - Engaged-external: output from loop on external reference, debug from loop.
// - Bypassed-internal: loop on, output from internal reference, debug from loop.
// - Bypassed-internal-low-power: loop off unless debug is active, output internal reference, debug clock only while debug is active.
// - Bypassed-external: loop on, output from external reference, debug from loop.
// - Bypassed-external-low-power: loop off unless debug is active, output external reference, debug clock only while debug is active.
// - Drive range, high gain, oscillator request, enable and stop enable.
// - Stop: loop off, no clocks, references per their stop enables.
// - The unit has no package pins; all ports are on-chip.
// - Source field picks loop, internal or external; fourth code reserved.
// - Bus divider field resets to divide by two.
// - Reference divider codes divide by 1 to 128, resetting to 1.
// - Reference select one picks internal, zero picks external.
module fllcs_clock_source_unit (
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic [1:0] addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rd_data_out,
    input  wire logic       dco_tick_in,
    input  wire logic       int_ref_tick_in,
    input  wire logic       ext_ref_tick_in,
    input  wire logic       stop_in,
    input  wire logic       bdm_active_in,
    input  wire logic       oscillator_ready_in,
    output logic            clock_unit_output_tick_out,
    output logic            bus_clock_tick_out,
    output logic            debug_clock_tick_out,
    output logic            loop_reference_tick_out,
    output logic            loop_enable_out,
    output logic      [8:0] internal_reference_trim_out,
    output logic            internal_reference_output_enable_out,
    output logic            external_reference_enable_out,
    output logic            oscillator_range_out,
    output logic            oscillator_high_gain_out,
    output logic            oscillator_request_out,
    output fllcs_pkg::fllcs_mode_t mode_out
);

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [7:0] trim;
        logic       fine_trim;
        logic [1:0] clock_source_select_act;
        logic [1:0] bus_divider_select_act;
        logic [6:0] div_cnt;
        logic [6:0] ref_cnt;
        logic       out_tick;
        logic       bus_tog;
        logic       bus_tick;
        logic       dbg_tog;
        logic       dbg_tick;
        logic       ref_tick;
        logic       loop_on;
        logic       reference_status;
        logic       osc_s1;
        logic       osc_s2;
        logic [7:0] rd_data;
        logic       int_en;
        logic       ext_en;
        fllcs_pkg::fllcs_mode_t mode;
    } fllcs_state_t;

    fllcs_state_t st;
    fllcs_state_t next_st;

    // Mask of ones for a power-of-two divide chosen by a select code.
    function automatic logic [6:0] fllcs_div_mask(input logic [2:0] sel);
        fllcs_div_mask = 7'(({7'h00, 1'b1} << sel) - 8'h01);
    endfunction : fllcs_div_mask

    function automatic fllcs_pkg::fllcs_mode_t fllcs_decode(
        input logic [1:0] clock_source_select,
        input logic       internal_reference_select,
        input logic       lp,
        input logic       stop
    );
        fllcs_pkg::fllcs_mode_t m;
        m = fllcs_pkg::FLLCS_LOOP_ENGAGED_INTERNAL;
        if (stop) begin
            m = fllcs_pkg::FLLCS_STOP;
        end else if (clock_source_select == fllcs_pkg::SRC_INTERNAL) begin
            m = lp ? fllcs_pkg::FLLCS_BYPASSED_INTERNAL_LOW_POWER
                   : fllcs_pkg::FLLCS_BYPASSED_INTERNAL;
        end else if (clock_source_select == fllcs_pkg::SRC_EXTERNAL) begin
            m = lp ? fllcs_pkg::FLLCS_BYPASSED_EXTERNAL_LOW_POWER
                   : fllcs_pkg::FLLCS_BYPASSED_EXTERNAL;
        end else if (!internal_reference_select) begin
            m = fllcs_pkg::FLLCS_LOOP_ENGAGED_EXTERNAL;
        end
        fllcs_decode = m;
    endfunction : fllcs_decode

    // ************************************************************
    // Next-state logic.
    // ************************************************************
    always_comb begin
        logic       src_tick;
        logic       lref_tick;
        logic       int_mode;
        logic       ext_mode;
        logic [6:0] bmask;
        logic [6:0] rmask;
        src_tick  = 1'b0;
        lref_tick = 1'b0;
        int_mode  = 1'b0;
        ext_mode  = 1'b0;
        bmask     = fllcs_div_mask({1'b0, st.bus_divider_select_act});
        rmask     = fllcs_div_mask(st.ctrl_one[fllcs_pkg::REFERENCE_DIVIDER_SELECT_HI:fllcs_pkg::REFERENCE_DIVIDER_SELECT_LO]);
        next_st   = st;

        // Register writes; the reserved source code is stored as the loop code.
        if (wr_in) begin
            unique case (addr_in)
                fllcs_pkg::ADDR_CTRL_ONE: begin
                    next_st.ctrl_one = wr_data_in;
                    if (wr_data_in[fllcs_pkg::CLOCK_SOURCE_SELECT_HI:fllcs_pkg::CLOCK_SOURCE_SELECT_LO]
                        == fllcs_pkg::SRC_RESERVED) begin
                        next_st.ctrl_one[fllcs_pkg::CLOCK_SOURCE_SELECT_HI:fllcs_pkg::CLOCK_SOURCE_SELECT_LO] =
                            fllcs_pkg::SRC_LOOP;
                    end
                end
                fllcs_pkg::ADDR_CTRL_TWO: next_st.ctrl_two  = wr_data_in;
                fllcs_pkg::ADDR_TRIM:     next_st.trim      = wr_data_in;
                fllcs_pkg::ADDR_STATUS:   next_st.fine_trim = wr_data_in[0];
            endcase
        end

        // Read data stands only in the cycle after the read strobe.
        next_st.rd_data = 8'h00;
        if (rd_in) begin
            unique case (addr_in)
                fllcs_pkg::ADDR_CTRL_ONE: next_st.rd_data = st.ctrl_one;
                fllcs_pkg::ADDR_CTRL_TWO: next_st.rd_data = st.ctrl_two;
                fllcs_pkg::ADDR_TRIM:     next_st.rd_data = st.trim;
                fllcs_pkg::ADDR_STATUS:   next_st.rd_data = {3'h0, st.reference_status, st.clock_source_select_act,
                                                             st.osc_s2, st.fine_trim};
            endcase
        end

        next_st.osc_s1 = oscillator_ready_in;
        next_st.osc_s2 = st.osc_s1;

        next_st.mode = fllcs_decode(st.ctrl_one[fllcs_pkg::CLOCK_SOURCE_SELECT_HI:fllcs_pkg::CLOCK_SOURCE_SELECT_LO],
                                    st.ctrl_one[fllcs_pkg::INTERNAL_REFERENCE_SELECT_BIT],
                                    st.ctrl_two[fllcs_pkg::LP_BIT], stop_in);
        // Low power turns the loop off in bypass unless debug is active.
        unique case (next_st.mode)
            fllcs_pkg::FLLCS_STOP:                        next_st.loop_on = 1'b0;
            fllcs_pkg::FLLCS_BYPASSED_INTERNAL_LOW_POWER,
            fllcs_pkg::FLLCS_BYPASSED_EXTERNAL_LOW_POWER: next_st.loop_on = bdm_active_in;
            default:                                      next_st.loop_on = 1'b1;
        endcase

        // Either reference, up to 5 MHz, may steer the loop.
        next_st.reference_status = st.ctrl_one[fllcs_pkg::INTERNAL_REFERENCE_SELECT_BIT];
        lref_tick = st.reference_status ? int_ref_tick_in : ext_ref_tick_in;
        next_st.ref_tick = 1'b0;
        if (lref_tick && st.loop_on) begin
            if ((st.ref_cnt & rmask) == rmask) begin
                next_st.ref_cnt  = 7'h00;
                next_st.ref_tick = 1'b1;
            end else begin
                next_st.ref_cnt = 7'(st.ref_cnt + 7'h01);
            end
        end

        // The selected source feeds the bus divider.
        unique case (st.clock_source_select_act)
            fllcs_pkg::SRC_INTERNAL: src_tick = int_ref_tick_in;
            fllcs_pkg::SRC_EXTERNAL: src_tick = ext_ref_tick_in;
            default:                 src_tick = dco_tick_in && st.loop_on;
        endcase
        next_st.out_tick = 1'b0;
        next_st.bus_tick = 1'b0;
        if (src_tick && !stop_in) begin
            if ((st.div_cnt & bmask) == bmask) begin
                next_st.div_cnt  = 7'h00;
                next_st.out_tick = 1'b1;
                next_st.bus_tick = st.bus_tog;
                next_st.bus_tog  = !st.bus_tog;
                // New source and ratio are taken only at a period boundary.
                next_st.clock_source_select_act = st.ctrl_one[fllcs_pkg::CLOCK_SOURCE_SELECT_HI:fllcs_pkg::CLOCK_SOURCE_SELECT_LO];
                next_st.bus_divider_select_act = st.ctrl_two[fllcs_pkg::BUS_DIVIDER_SELECT_HI:fllcs_pkg::BUS_DIVIDER_SELECT_LO];
            end else begin
                next_st.div_cnt = 7'(st.div_cnt + 7'h01);
            end
        end

        // Debug clock halves the loop oscillator whenever the loop runs.
        next_st.dbg_tick = 1'b0;
        if (dco_tick_in && st.loop_on) begin
            next_st.dbg_tick = st.dbg_tog;
            next_st.dbg_tog  = !st.dbg_tog;
        end

        // Reference enables; in stop each stays on only by its stop enable.
        int_mode = st.mode == fllcs_pkg::FLLCS_LOOP_ENGAGED_INTERNAL ||
                   st.mode == fllcs_pkg::FLLCS_BYPASSED_INTERNAL ||
                   st.mode == fllcs_pkg::FLLCS_BYPASSED_INTERNAL_LOW_POWER;
        ext_mode = st.mode == fllcs_pkg::FLLCS_LOOP_ENGAGED_EXTERNAL ||
                   st.mode == fllcs_pkg::FLLCS_BYPASSED_EXTERNAL ||
                   st.mode == fllcs_pkg::FLLCS_BYPASSED_EXTERNAL_LOW_POWER;
        if (next_st.mode == fllcs_pkg::FLLCS_STOP) begin
            if (st.mode != fllcs_pkg::FLLCS_STOP) begin
                next_st.int_en = st.ctrl_one[fllcs_pkg::IRSTP_BIT] &&
                                 (st.ctrl_one[fllcs_pkg::IRCLK_BIT] || int_mode);
                next_st.ext_en = st.ctrl_two[fllcs_pkg::ERSTP_BIT] &&
                                 (st.ctrl_two[fllcs_pkg::ERCLK_BIT] || ext_mode);
            end
        end else begin
            next_st.int_en = st.ctrl_one[fllcs_pkg::IRCLK_BIT] ||
                             next_st.mode == fllcs_pkg::FLLCS_LOOP_ENGAGED_INTERNAL ||
                             next_st.mode == fllcs_pkg::FLLCS_BYPASSED_INTERNAL ||
                             next_st.mode == fllcs_pkg::FLLCS_BYPASSED_INTERNAL_LOW_POWER;
            next_st.ext_en = st.ctrl_two[fllcs_pkg::ERCLK_BIT] ||
                             next_st.mode == fllcs_pkg::FLLCS_LOOP_ENGAGED_EXTERNAL ||
                             next_st.mode == fllcs_pkg::FLLCS_BYPASSED_EXTERNAL ||
                             next_st.mode == fllcs_pkg::FLLCS_BYPASSED_EXTERNAL_LOW_POWER;
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st          <= '0;
            st.ctrl_one <= fllcs_pkg::CTRL_ONE_RESET;
            st.ctrl_two <= fllcs_pkg::CTRL_TWO_RESET;
            st.trim     <= fllcs_pkg::TRIM_RESET;
            st.bus_divider_select_act <= fllcs_pkg::CTRL_TWO_RESET[fllcs_pkg::BUS_DIVIDER_SELECT_HI:fllcs_pkg::BUS_DIVIDER_SELECT_LO];
            st.clock_source_select_act <= fllcs_pkg::SRC_LOOP;
            st.loop_on  <= 1'b1;
            st.reference_status   <= 1'b1;
            st.int_en   <= 1'b1;
            st.mode     <= fllcs_pkg::FLLCS_LOOP_ENGAGED_INTERNAL;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs; all on-chip, none reaches a package pin.
    // ************************************************************
    assign rd_data_out                          = st.rd_data;
    assign clock_unit_output_tick_out           = st.out_tick;
    assign bus_clock_tick_out                   = st.bus_tick;
    assign debug_clock_tick_out                 = st.dbg_tick;
    assign loop_reference_tick_out              = st.ref_tick;
    assign loop_enable_out                      = st.loop_on;
    assign internal_reference_trim_out          = {st.trim, st.fine_trim};
    assign internal_reference_output_enable_out = st.int_en;
    assign external_reference_enable_out        = st.ext_en;
    assign oscillator_range_out                 = st.ctrl_two[fllcs_pkg::RANGE_BIT];
    assign oscillator_high_gain_out             = st.ctrl_two[fllcs_pkg::HGO_BIT];
    assign oscillator_request_out               = st.ctrl_two[fllcs_pkg::OSCILLATOR_REQUEST_BIT];
    assign mode_out                             = st.mode;

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking fllcs_cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_bus_half_rate: assert property (
        bus_clock_tick_out |-> clock_unit_output_tick_out
    ) else $error("bus tick without unit output tick");

    chk_debug_from_loop: assert property (
        debug_clock_tick_out |-> $past(dco_tick_in) && $past(st.loop_on)
    ) else $error("debug tick without loop oscillator tick");

    chk_low_power_quiet: assert property (
        (!bdm_active_in && (st.mode == fllcs_pkg::FLLCS_BYPASSED_INTERNAL_LOW_POWER ||
          st.mode == fllcs_pkg::FLLCS_BYPASSED_EXTERNAL_LOW_POWER)) [*3]
        |-> !loop_enable_out && !debug_clock_tick_out
    ) else $error("loop or debug clock alive in low power bypass");

    chk_stop_no_clocks: assert property (
        stop_in [*3] |-> !clock_unit_output_tick_out && !debug_clock_tick_out &&
                         !loop_enable_out
    ) else $error("clock produced in stop");

    chk_bus_div_ratio: assert property (
        clock_unit_output_tick_out |-> st.div_cnt == 7'h00
    ) else $error("unit output tick off the divider boundary");

    chk_ref_div_ratio: assert property (
        loop_reference_tick_out |-> st.ref_cnt == 7'h00
    ) else $error("loop reference tick off the divider boundary");

    chk_trim_write: assert property (
        wr_in && addr_in == fllcs_pkg::ADDR_TRIM
        |=> internal_reference_trim_out[8:1] == $past(wr_data_in)
    ) else $error("trim write not reflected on trim output");

    chk_source_switch: assert property (
        !$stable(st.clock_source_select_act) |-> clock_unit_output_tick_out
    ) else $error("source switched away from a period boundary");

    chk_read_window: assert property (
        !$past(rd_in) |-> rd_data_out == 8'h00
    ) else $error("read data outside its cycle");

    chk_reserved_source: assert property (
        wr_in && addr_in == fllcs_pkg::ADDR_CTRL_ONE
        |=> st.ctrl_one[fllcs_pkg::CLOCK_SOURCE_SELECT_HI:fllcs_pkg::CLOCK_SOURCE_SELECT_LO] != fllcs_pkg::SRC_RESERVED
    ) else $error("reserved source code stored");

    chk_loop_ref_source: assert property (
        loop_reference_tick_out |->
            $past(st.reference_status ? int_ref_tick_in : ext_ref_tick_in) && $past(st.loop_on)
    ) else $error("loop reference tick from the wrong reference");

    chk_stop_int_off: assert property (
        mode_out == fllcs_pkg::FLLCS_STOP && $past(mode_out) != fllcs_pkg::FLLCS_STOP &&
        !$past(st.ctrl_one[fllcs_pkg::IRSTP_BIT]) |-> !internal_reference_output_enable_out
    ) else $error("internal reference left on in stop without its stop enable");

    chk_mode_one_hot: assert property (
        $onehot(mode_out)
    ) else $error("mode is not one-hot");

endmodule : fllcs_clock_source_unit
`default_nettype wire

// ### verif/fllcs_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module fllcs_far_side (
    input  wire logic core_clk_in,
    input  wire logic rst_b_in,
    input  wire logic osc_request_in,
    output logic      dco_tick_out,
    output logic      int_ref_tick_out,
    output logic      ext_ref_tick_out,
    output logic      osc_ready_out
);
    // ************************************************************
    // Reference sources of distinct periods: loop 1, internal 2, external 3.
    // ************************************************************
    int ph;
    int up;
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ph <= 0;
            up <= 0;
        end else begin
            ph <= (ph + 1) % 6;
            up <= osc_request_in ? ((up < 8) ? up + 1 : up) : 0;
        end
    end
    assign dco_tick_out     = rst_b_in;
    assign int_ref_tick_out = rst_b_in && (ph % 2 == 0);
    assign ext_ref_tick_out = rst_b_in && (ph % 3 == 0);
    assign osc_ready_out    = (up == 8);
endmodule : fllcs_far_side
`default_nettype wire

// ### verif/fll_clock_source_modes_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fll_clock_source_modes_tb;
    logic       clk, rst_b, wr, rd, stp, bdm, loop_controlled_oscillator, irt, ert, ordy;
    logic [1:0] addr;
    logic [7:0] wdat, rdat;
    logic       o_t, b_t, d_t, r_t, lpe, ien, een, rng, hg, req;
    logic [8:0] trm;
    fllcs_pkg::fllcs_mode_t mode;
    int n_mismatch, total_checks, cyc, seed, g;
    logic [7:0] t8;
    logic       ft;
    int cs[6] = '{0, 0, 1, 1, 2, 2};
    int ir[6] = '{1, 0, 1, 1, 0, 0};
    int lp[6] = '{0, 0, 0, 1, 0, 1};
    int bd[6] = '{0, 1, 2, 3, 1, 0};
    logic [6:0] md[6] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20};

    fllcs_clock_source_unit dut (.core_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
        .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .dco_tick_in(loop_controlled_oscillator),
        .int_ref_tick_in(irt), .ext_ref_tick_in(ert), .stop_in(stp), .bdm_active_in(bdm),
        .oscillator_ready_in(ordy), .clock_unit_output_tick_out(o_t),
        .bus_clock_tick_out(b_t), .debug_clock_tick_out(d_t),
        .loop_reference_tick_out(r_t), .loop_enable_out(lpe),
        .internal_reference_trim_out(trm), .internal_reference_output_enable_out(ien),
        .external_reference_enable_out(een), .oscillator_range_out(rng),
        .oscillator_high_gain_out(hg), .oscillator_request_out(req), .mode_out(mode));
    fllcs_far_side far (.core_clk_in(clk), .rst_b_in(rst_b), .osc_request_in(req),
        .dco_tick_out(loop_controlled_oscillator), .int_ref_tick_out(irt), .ext_ref_tick_out(ert),
        .osc_ready_out(ordy));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rchk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdat, e);
    endtask : rchk

    function automatic logic tsig(input int s);
        case (s)
            0: return o_t;
            1: return b_t;
            2: return d_t;
            default: return r_t;
        endcase
    endfunction : tsig

    // Cycles between two ticks of the chosen output; 0 if none within lim.
    task automatic gap(input int s, input int lim, output int n);
        int k;
        n = 0;
        for (k = 0; k < lim && !tsig(s); k++) @(posedge clk) #1;
        if (k == lim) return;
        for (k = 1; k <= lim; k++) begin
            @(posedge clk) #1;
            if (tsig(s)) begin
                n = k;
                return;
            end
        end
    endtask : gap

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        seed = 32'h8fbbeac2;
        {rst_b, wr, rd, stp, bdm, addr, wdat} = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rchk(fllcs_pkg::ADDR_CTRL_ONE, 8'h04);
        rchk(fllcs_pkg::ADDR_CTRL_TWO, 8'h40);
        rchk(fllcs_pkg::ADDR_TRIM, 8'h80);
        rchk(fllcs_pkg::ADDR_STATUS, 8'h10);
        check({mode, lpe, trm}, {7'h01, 1'b1, 9'h100});
        gap(0, 100, g); gap(0, 100, g);
        check(g, 2);
        for (int i = 0; i < 6; i++) begin
            wreg(fllcs_pkg::ADDR_CTRL_TWO, {bd[i][1:0], 2'h0, lp[i][0], 3'h0});
            wreg(fllcs_pkg::ADDR_CTRL_ONE, {cs[i][1:0], 3'(i + 2), ir[i][0], 2'h0});
            repeat (4) @(posedge clk);
            #1 check({mode, lpe}, {md[i], 1'(lp[i] == 0)});
            check({ien, een}, {1'(cs[i] < 2 && ir[i] > 0), 1'(cs[i] > 1 || ir[i] < 1)});
            gap(0, 100, g); gap(0, 100, g);
            check(g, (cs[i] == 0 ? 1 : cs[i] + 1) << bd[i]);
            gap(1, 100, g); gap(1, 100, g);
            check(g, (cs[i] == 0 ? 2 : 2 * cs[i] + 2) << bd[i]);
            gap(2, 40, g); gap(2, 40, g);
            check(g, lp[i] ? 0 : 2);
            if (!lp[i]) begin
                gap(3, 900, g); gap(3, 900, g);
                check(g, (ir[i] ? 2 : 3) << (i + 2));
            end
        end
        bdm <= 1'b1;
        repeat (4) @(posedge clk);
        gap(2, 40, g); gap(2, 40, g);
        check({lpe, 8'(g)}, {1'b1, 8'h02});
        bdm <= 1'b0;
        wreg(fllcs_pkg::ADDR_CTRL_ONE, 8'hc6);
        rchk(fllcs_pkg::ADDR_CTRL_ONE, 8'h06);
        stp <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check({mode, lpe, ien, een}, {7'h40, 1'b0, 1'b0, 1'b0});
        gap(0, 40, g);
        check(g, 0);
        gap(2, 40, g);
        check(g, 0);
        stp <= 1'b0;
        t8 = 8'($random(seed));
        ft = t8[3];
        wreg(fllcs_pkg::ADDR_TRIM, t8);
        wreg(fllcs_pkg::ADDR_STATUS, {7'h0, ft});
        rchk(fllcs_pkg::ADDR_TRIM, t8);
        check(trm, {t8, ft});
        wreg(fllcs_pkg::ADDR_CTRL_TWO, 8'h34);
        repeat (2) @(posedge clk);
        #1 check({rng, hg, req}, 3'h7);
        repeat (16) @(posedge clk);
        rchk(fllcs_pkg::ADDR_STATUS, {7'h09, ft});
        tally_and_finish();
    end
endmodule : fll_clock_source_modes_tb
`default_nettype wire
